/* File: hw/flash_sector_lock_control.v */
/*
  sector protection flags, protection lock bit with hardware and software lock,
  global protect/unprotect decode of status writes, and the serial read of one
  sector's protection flag.
  assumes: status writes and sector commands arrive as one-cycle pulses from the
  command decoder on core_clk_in; serial pins and wp pin are asynchronous and are
  synchronised here; the serial clock is at most an eighth of core_clk_in.
*/
`timescale 1ns/1ps
`include "sector_lock_defines.vh"
module flash_sector_lock_control #(
  parameter NUM_SECTORS = 64,
  parameter SECTOR_BITS = 6
) (
  // clock and reset
  input  wire                   core_clk_in,
  input  wire                   nrst_in,
  // serial interface pins
  input  wire                   sck_in,
  input  wire                   cs_n_in,
  input  wire                   si_in,
  output reg                    so_out,
  output reg                    so_oe_n_out,
  // write-protect pin
  input  wire                   wp_n_in,
  // status register write from command decoder
  input  wire                   sr_write_in,
  input  wire [7:0]             sr_write_data_in,
  // sector protect / unprotect from command decoder
  input  wire                   sector_protect_in,
  input  wire                   sector_unprotect_in,
  input  wire [SECTOR_BITS-1:0] sector_sel_in,
  // other status bits owned elsewhere
  input  wire                   prog_error_in,
  input  wire                   write_enable_latch_in,
  input  wire                   busy_in,
  // status and protection state
  output wire [7:0]             status_out,
  output wire                   protection_lock_bit_out,
  output wire                   hw_lock_out,
  output wire                   sw_lock_out,
  output wire [1:0]             protection_summary_field_out,
  output wire [NUM_SECTORS-1:0] sector_flags_out
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  wire sck_s;
  wire cs_n_s;
  wire si_s;
  wire wp_n_s;

  pin_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .pin_in      (sck_in),
    .sync_out    (sck_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .pin_in      (cs_n_in),
    .sync_out    (cs_n_s)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_sync_si (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .pin_in      (si_in),
    .sync_out    (si_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sync_wp (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .pin_in      (wp_n_in),
    .sync_out    (wp_n_s)
  );

  // --------------------------------------------------------------------------
  // serial clock edge detection
  // --------------------------------------------------------------------------
  reg  sck_d;
  wire sck_rise;
  wire sck_fall;

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d & ~cs_n_s;

  // --------------------------------------------------------------------------
  // lock state
  // --------------------------------------------------------------------------
  reg                   lock_bit;
  reg [NUM_SECTORS-1:0] flags;
  wire                  hw_lock;
  wire                  sw_lock;
  wire [3:0]            global_code;
  wire                  global_allowed;
  reg                   next_lock_bit;
  reg [NUM_SECTORS-1:0] next_flags;

  // hardware lock needs the pin asserted and the lock bit set
  assign hw_lock        = ~wp_n_s & lock_bit;
  // software lock: pin deasserted, lock bit set
  assign sw_lock        = wp_n_s & lock_bit;
  assign global_code    = sr_write_data_in[`SR_GLOBAL_HI:`SR_GLOBAL_LO];
  // a write that clears the lock finds the flags still soft-locked
  assign global_allowed = ~lock_bit;

  // --------------------------------------------------------------------------
  // next state of lock bit and sector flags
  // --------------------------------------------------------------------------
  always @* begin
    next_lock_bit = lock_bit;
    next_flags    = flags;
    if (sr_write_in && !hw_lock) begin
      // only the lock bit is stored, bits 5:2 are decoded
      // 0fh clears and f0h sets the lock alone, both carry odd codes
      next_lock_bit = sr_write_data_in[`SR_LOCK_POS];
      if (global_allowed) begin
        // ffh raises the lock and protects all sectors together
        if (global_code == `GLOBAL_PROTECT) begin
          next_flags = {NUM_SECTORS{1'b1}};
        end else if (global_code == `GLOBAL_UNPROTECT) begin
          next_flags = {NUM_SECTORS{1'b0}};
        end else begin
          next_flags = flags;
        end
      end
    end else if (!lock_bit) begin
      // protect wins over unprotect in the same cycle
      if (sector_protect_in) begin
        next_flags[sector_sel_in] = 1'b1;
      end else if (sector_unprotect_in) begin
        next_flags[sector_sel_in] = 1'b0;
      end
    end
  end

  // power-up and device reset clear the lock bit; wp pin never touches flags
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_bit <= `LOCK_RESET;
      flags    <= {NUM_SECTORS{`FLAG_RESET}};
    end else begin
      lock_bit <= next_lock_bit;
      flags    <= next_flags;
    end
  end

  // --------------------------------------------------------------------------
  // status register view
  // --------------------------------------------------------------------------
  reg [1:0] summary;
  reg [1:0] next_summary;
  reg       prog_error;
  reg       write_enable_latch;
  reg       busy;

  // summary of the flags as they will stand after this edge
  always @* begin
    if (&next_flags) begin
      next_summary = `SUMMARY_ALL;
    end else if (~|next_flags) begin
      next_summary = `SUMMARY_NONE;
    end else begin
      next_summary = `SUMMARY_SOME;
    end
  end

  // status word comes from flops, pass-through bits one cycle behind their inputs
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      summary            <= `SUMMARY_RESET;
      prog_error         <= 1'b0;
      write_enable_latch <= 1'b0;
      busy               <= 1'b0;
    end else begin
      summary            <= next_summary;
      prog_error         <= prog_error_in;
      write_enable_latch <= write_enable_latch_in;
      busy               <= busy_in;
    end
  end

  // bits 5:2 are live state, never the written data
  assign status_out[`SR_LOCK_POS]                     = lock_bit;
  assign status_out[`SR_RSVD_POS]                     = 1'b0;
  assign status_out[`SR_PROG_ERR_POS]                 = prog_error;
  assign status_out[`SR_WP_POS]                       = wp_n_s;
  assign status_out[`SR_SUMMARY_HI:`SR_SUMMARY_LO]    = summary;
  assign status_out[`SR_WEL_POS]                      = write_enable_latch;
  assign status_out[`SR_BUSY_POS]                     = busy;

  assign protection_lock_bit_out      = lock_bit;
  assign hw_lock_out                  = hw_lock;
  assign sw_lock_out                  = sw_lock;
  assign protection_summary_field_out = summary;
  assign sector_flags_out             = flags;

  // --------------------------------------------------------------------------
  // serial protection read state machine
  // --------------------------------------------------------------------------
  localparam ST_OPCODE = 2'b00;
  localparam ST_ADDR   = 2'b01;
  localparam ST_DATA   = 2'b10;
  localparam ST_IGNORE = 2'b11;

  // --------------------------------------------------------------------------
  // frame bit counter end points, cut to the counter width
  // --------------------------------------------------------------------------
  localparam integer OPC_LAST_FULL  = `OPCODE_BITS - 1;
  localparam integer SECT_LAST_FULL = `ADDR_BITS - 1 - `SECTOR_ADDR_LSB;
  localparam integer ADDR_LAST_FULL = `ADDR_BITS - 1;
  localparam [4:0]   OPC_LAST       = OPC_LAST_FULL[4:0];
  localparam [4:0]   SECT_LAST      = SECT_LAST_FULL[4:0];
  localparam [4:0]   ADDR_LAST      = ADDR_LAST_FULL[4:0];

  reg [1:0]             state;
  reg [1:0]             next_state;
  reg [4:0]             bit_cnt;
  reg [4:0]             next_bit_cnt;
  reg [7:0]             in_shift;
  reg [7:0]             next_in_shift;
  reg [SECTOR_BITS-1:0] sector_idx;
  reg [SECTOR_BITS-1:0] next_sector_idx;
  wire [7:0]            shifted;

  assign shifted = {in_shift[6:0], si_s};

  always @* begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_in_shift   = in_shift;
    next_sector_idx = sector_idx;
    case (state)
      ST_OPCODE: begin
        if (sck_rise) begin
          next_in_shift = shifted;
          if (bit_cnt == OPC_LAST) begin
            next_bit_cnt = 5'h00;
            if (shifted == `OPC_READ_PROT) begin
              next_state = ST_ADDR;
            end else begin
              next_state = ST_IGNORE;
            end
          end else begin
            next_bit_cnt = bit_cnt + 5'h01;
          end
        end
      end
      ST_ADDR: begin
        if (sck_rise) begin
          next_in_shift = shifted;
          // address bits 21:16 pick the 64 KB sector
          if (bit_cnt == SECT_LAST) begin
            next_sector_idx = shifted[SECTOR_BITS-1:0];
          end
          if (bit_cnt == ADDR_LAST) begin
            next_bit_cnt = 5'h00;
            next_state   = ST_DATA;
          end else begin
            next_bit_cnt = bit_cnt + 5'h01;
          end
        end
      end
      ST_DATA: begin
        next_state = ST_DATA;
      end
      ST_IGNORE: begin
        next_state = ST_IGNORE;
      end
      default: begin
        next_state = ST_OPCODE;
      end
    endcase
  end

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state      <= ST_OPCODE;
      bit_cnt    <= 5'h00;
      in_shift   <= 8'h00;
      sector_idx <= {SECTOR_BITS{1'b0}};
    end else if (cs_n_s) begin
      // release of chip select ends any command mid-byte
      state      <= ST_OPCODE;
      bit_cnt    <= 5'h00;
      in_shift   <= 8'h00;
      sector_idx <= sector_idx;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      in_shift   <= next_in_shift;
      sector_idx <= next_sector_idx;
    end
  end

  // --------------------------------------------------------------------------
  // serial output: repeating byte FFh or 00h on each falling edge
  // --------------------------------------------------------------------------
  reg [7:0] out_shift;
  reg [2:0] out_cnt;
  wire [7:0] prot_byte;

  // only the sector flag shapes the byte, wp pin is not looked at
  assign prot_byte = flags[sector_idx] ? `PROT_BYTE_SET : `PROT_BYTE_CLR;

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      so_out      <= 1'b0;
      so_oe_n_out <= 1'b1;
      out_shift   <= 8'h00;
      out_cnt     <= 3'h0;
    end else if (cs_n_s) begin
      so_out      <= 1'b0;
      so_oe_n_out <= 1'b1;
      out_shift   <= 8'h00;
      out_cnt     <= 3'h0;
    end else if (state == ST_DATA && sck_fall) begin
      // byte reloads every eight bits so a flag change shows next byte
      if (out_cnt == 3'h0) begin
        so_out    <= prot_byte[7];
        out_shift <= {prot_byte[6:0], 1'b0};
      end else begin
        so_out    <= out_shift[7];
        out_shift <= {out_shift[6:0], 1'b0};
      end
      out_cnt     <= out_cnt + 3'h1;
      // first falling edge in the data state takes the pin
      so_oe_n_out <= 1'b0;
    end
  end

endmodule

/* File: hw/sector_lock_defines.vh */
/*
  constants for the sector protection and lock controller: status register
  field positions, global protect codes, serial command framing and reset values.
  assumes inclusion by flash_sector_lock_control.v only; definitions only.
*/
// Functional notes
// - lock clear: status write 00h clears all sector flags, lock stays zero
// - lock clear: status write 7Fh sets all sector flags, lock stays zero
// - lock clear: status write FFh sets all flags and sets lock together
// - wp pin high: status write 0Fh clears lock, flags untouched
// - status write F0h sets lock from zero, flags untouched
// - only bit 7 of a status write is stored; bits 5:2 only decoded
// - status readback bits 5:2 show program error, live wp pin and protection summary
// - after address, output repeats FFh for protected sector, 00h otherwise
// - chip select release ends read at any bit, output goes high impedance
// - protection read data carries only the sector flag, no wp info
// - hardware lock active exactly when wp pin low and lock bit one
// - hardware lock ignores sector commands and status writes entirely
// - status write clearing lock does no global protect or unprotect
// - wp held low: set lock stays set until power cycle or reset
// - wp pin high: lock may be set, blocking sector commands
// - write raising lock from zero also performs encoded global operation
// - software lock: lock may be cleared, sector and global ops ignored
// - lock zero: sector and global ops work, lock may be raised
// - bits 5:2 neither all ones nor all zeros: flags unchanged
// - lock bit cleared after power-up and device reset
`ifndef SECTOR_LOCK_DEFINES_VH
`define SECTOR_LOCK_DEFINES_VH

// ----------------------------------------------------------------------------
// status register layout
// ----------------------------------------------------------------------------
`define SR_LOCK_POS        7
`define SR_RSVD_POS        6
`define SR_PROG_ERR_POS    5
`define SR_WP_POS          4
`define SR_SUMMARY_HI      3
`define SR_SUMMARY_LO      2
`define SR_WEL_POS         1
`define SR_BUSY_POS        0
`define SR_GLOBAL_HI       5
`define SR_GLOBAL_LO       2

// ----------------------------------------------------------------------------
// global protect codes and summary encodings
// ----------------------------------------------------------------------------
`define GLOBAL_PROTECT     4'hf
`define GLOBAL_UNPROTECT   4'h0
`define SUMMARY_NONE       2'h0
`define SUMMARY_SOME       2'h1
`define SUMMARY_ALL        2'h3

// ----------------------------------------------------------------------------
// serial command framing
// ----------------------------------------------------------------------------
`define OPC_READ_PROT      8'h3c
`define OPCODE_BITS        8
`define ADDR_BITS          24
`define SECTOR_ADDR_LSB    16
`define PROT_BYTE_SET      8'hff
`define PROT_BYTE_CLR      8'h00

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define LOCK_RESET         1'b0
`define FLAG_RESET         1'b1
`define SUMMARY_RESET      2'h3

`endif

/* File: hw/pin_sync.v */
/*
  two flip-flop synchroniser for one pin.
  assumes the pin is asynchronous to core_clk_in; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire core_clk_in,
  input  wire nrst_in,
  // pin in, synchronised level out
  input  wire pin_in,
  output reg  sync_out
);

  reg meta;

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta     <= pin_in;
      sync_out <= meta;
    end
  end

endmodule

/* File: sim/lock_checker_asserts.sv */
/* port checker for flash_sector_lock_control.
   assumes one clock domain; bound to the module below. */
`timescale 1ns/1ps
module lock_checker #(
  parameter NUM_SECTORS = 64,
  parameter SECTOR_BITS = 6
) (
  // clock, reset and serial pins
  input wire                   core_clk_in,
  input wire                   nrst_in,
  input wire                   cs_n_in,
  input wire                   so_oe_n_out,
  // commands
  input wire                   sr_write_in,
  input wire [7:0]             sr_write_data_in,
  input wire                   sector_protect_in,
  input wire                   sector_unprotect_in,
  input wire [SECTOR_BITS-1:0] sector_sel_in,
  // state
  input wire [7:0]             status_out,
  input wire                   protection_lock_bit_out,
  input wire                   hw_lock_out,
  input wire [NUM_SECTORS-1:0] sector_flags_out
);
  wire [3:0] gcode = sr_write_data_in[5:2];
  wire       lck   = protection_lock_bit_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_hw_lock_form: assert property (hw_lock_out == (!status_out[4] && lck))
    else $error("hw lock form");
  a_hw_freeze: assert property (hw_lock_out |=> $stable(sector_flags_out) && $stable(lck))
    else $error("hw lock not frozen");
  a_global_clr: assert property (sr_write_in && !lck && gcode == 4'h0 |=> sector_flags_out == '0)
    else $error("global clear missed");
  a_global_set: assert property (sr_write_in && !lck && gcode == 4'hf |=> &sector_flags_out)
    else $error("global set missed");
  a_lock_store: assert property (sr_write_in && !hw_lock_out |=> lck == $past(sr_write_data_in[7]))
    else $error("lock not stored");
  a_odd_code: assert property (sr_write_in && gcode != 4'h0 && gcode != 4'hf |=> $stable(sector_flags_out))
    else $error("flags changed");
  a_sector_blk: assert property ((sector_protect_in || sector_unprotect_in) && lck |=> $stable(sector_flags_out))
    else $error("locked sector changed");
  a_sector_set: assert property (sector_protect_in && !lck && !sr_write_in |=> sector_flags_out[$past(sector_sel_in)])
    else $error("sector not protected");
  a_cs_release: assert property (cs_n_in [*6] |-> so_oe_n_out)
    else $error("so driven while idle");
  c_hw_write: cover property (hw_lock_out && sr_write_in);
  c_read_drive: cover property ($fell(so_oe_n_out));
  c_lock_raise: cover property (sr_write_in && !lck && sr_write_data_in[7]);
endmodule

bind flash_sector_lock_control lock_checker #(.NUM_SECTORS(NUM_SECTORS), .SECTOR_BITS(SECTOR_BITS)) u_lock_checker (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in), .so_oe_n_out(so_oe_n_out),
  .sr_write_in(sr_write_in), .sr_write_data_in(sr_write_data_in), .sector_protect_in(sector_protect_in),
  .sector_unprotect_in(sector_unprotect_in), .sector_sel_in(sector_sel_in), .status_out(status_out),
  .protection_lock_bit_out(protection_lock_bit_out), .hw_lock_out(hw_lock_out),
  .sector_flags_out(sector_flags_out)
);

/* File: sim/spi_host_model.sv */
/* serial host model: one frame of opcode and address, then reply bits.
   assumes mode 0 and an sck of eight core cycles. */
`timescale 1ns/1ps
module spi_host_model (
  // clock and device reply
  input  wire  core_clk_in,
  input  wire  so_in,
  input  wire  so_oe_n_in,
  // host pins
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // msb first; reply sampled late in the high phase
  task automatic frame(input logic [7:0] opc, input logic [23:0] addr, input int nout,
                       output logic [63:0] rx, output int miss);
    logic [31:0] cmd;
    cmd = {opc, addr};
    rx = '0;
    miss = 0;
    @(posedge core_clk_in);
    cs_n_out <= 1'b0;
    for (int i = 0; i < 32 + nout; i++) begin
      if (i < 32) si_out <= cmd[31-i];
      repeat (4) @(posedge core_clk_in);
      sck_out <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      if (i >= 32) begin
        rx = {rx[62:0], so_oe_n_in ? 1'b1 : so_in};
        miss += so_oe_n_in;
      end
      sck_out <= 1'b0;
    end
    repeat (4) @(posedge core_clk_in);
    cs_n_out <= 1'b1;
    si_out <= ~si_out;
    repeat (6) @(posedge core_clk_in);
  endtask
endmodule

/* File: sim/tb_flash_sector_lock_control.sv */
/* self-checking bench for flash_sector_lock_control against a model.
   assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb_flash_sector_lock_control;
  logic        core_clk_in, nrst_in, wp_n_in, sr_write_in, prog_error_in, write_enable_latch_in, busy_in;
  logic        sector_protect_in, sector_unprotect_in;
  logic [7:0]  sr_write_data_in;
  logic [5:0]  sector_sel_in;
  wire         sck_in, cs_n_in, si_in, so_out, so_oe_n_out, protection_lock_bit_out, hw_lock_out, sw_lock_out;
  wire  [7:0]  status_out;
  wire  [1:0]  protection_summary_field_out;
  wire  [63:0] sector_flags_out;
  logic [63:0] m_flags;
  logic        m_lock;
  int          errors, n_tests;

  flash_sector_lock_control u_flash_sector_lock_control (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in),
    .so_out(so_out), .so_oe_n_out(so_oe_n_out), .wp_n_in(wp_n_in), .sr_write_in(sr_write_in),
    .sr_write_data_in(sr_write_data_in), .sector_protect_in(sector_protect_in),
    .sector_unprotect_in(sector_unprotect_in), .sector_sel_in(sector_sel_in), .prog_error_in(prog_error_in),
    .write_enable_latch_in(write_enable_latch_in), .busy_in(busy_in), .status_out(status_out),
    .protection_lock_bit_out(protection_lock_bit_out), .hw_lock_out(hw_lock_out), .sw_lock_out(sw_lock_out),
    .protection_summary_field_out(protection_summary_field_out), .sector_flags_out(sector_flags_out));
  spi_host_model u_spi_host_model (
    .core_clk_in(core_clk_in), .so_in(so_out), .so_oe_n_in(so_oe_n_out),
    .sck_out(sck_in), .cs_n_out(cs_n_in), .si_out(si_in));

  // ---------------------------------------------------------------
  // checking and stimulus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_state;
    logic [1:0] sum;
    sum = &m_flags ? 2'h3 : (|m_flags ? 2'h1 : 2'h0);
    chk("lock", protection_lock_bit_out, m_lock);
    chk("flags", sector_flags_out, m_flags);
    chk("hw_lock", hw_lock_out, !wp_n_in && m_lock);
    chk("sw_lock", sw_lock_out, wp_n_in && m_lock);
    chk("summary", protection_summary_field_out, sum);
    chk("status", status_out, {m_lock, 1'b0, prog_error_in, wp_n_in, sum, write_enable_latch_in, busy_in});
  endtask
  task automatic pulse(input logic wr, input logic [7:0] d, input logic pr, input logic un, input logic [5:0] s);
    @(posedge core_clk_in);
    sr_write_in <= wr;
    sr_write_data_in <= d;
    sector_protect_in <= pr;
    sector_unprotect_in <= un;
    sector_sel_in <= s;
    prog_error_in <= 1'($urandom);
    write_enable_latch_in <= 1'($urandom);
    busy_in <= 1'($urandom);
    if (wr && !(!wp_n_in && m_lock)) begin
      if (!m_lock && d[5:2] == 4'hf) m_flags = '1;
      else if (!m_lock && d[5:2] == 4'h0) m_flags = '0;
      m_lock = d[7];
    end else if (!wr && !m_lock && pr) m_flags[s] = 1'b1;
    else if (!wr && !m_lock && un) m_flags[s] = 1'b0;
    @(posedge core_clk_in);
    sr_write_in <= 1'b0;
    sector_protect_in <= 1'b0;
    sector_unprotect_in <= 1'b0;
    #1 check_state;
  endtask
  task automatic set_wp(input logic v);
    @(posedge core_clk_in);
    wp_n_in <= v;
    repeat (3) @(posedge core_clk_in);
  endtask
  task automatic results;
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    #100000;
    errors++;
    results;
  end
  initial begin
    logic [63:0] rx;
    int          miss, n;
    logic [5:0]  s;
    logic [7:0]  codes [11];
    {nrst_in, wp_n_in, sr_write_in, sr_write_data_in, sector_protect_in, sector_unprotect_in} = 13'h0800;
    {sector_sel_in, prog_error_in, write_enable_latch_in, busy_in} = 9'h000;
    m_flags = '1;
    m_lock = 1'b0;
    void'($urandom(32'hc37f));
    repeat (4) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    #1 check_state;
    codes = '{8'h00, 8'hff, 8'h00, 8'h00, 8'hf0, 8'h7f, 8'h7f, 8'h84, 8'h0f, 8'h83, 8'h0f};
    foreach (codes[i]) pulse(1'b1, codes[i], 1'b0, 1'b0, 6'h0);
    set_wp(1'b0);
    pulse(1'b0, 8'h00, 1'b0, 1'b1, 6'h3f);
    pulse(1'b1, 8'hff, 1'b0, 1'b0, 6'h0);
    pulse(1'b1, 8'h0f, 1'b0, 1'b0, 6'h0);
    pulse(1'b1, 8'h00, 1'b0, 1'b0, 6'h0);
    pulse(1'b0, 8'h00, 1'b1, 1'b1, 6'h05);
    for (int i = 0; i < 60; i++) begin
      if (i % 10 == 0) set_wp(1'($urandom));
      pulse(1'($urandom % 3 == 0), 8'($urandom), 1'($urandom), 1'($urandom), 6'($urandom));
    end
    @(posedge core_clk_in);
    nrst_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    m_lock = 1'b0;
    m_flags = '1;
    #1 check_state;
    for (int i = 0; i < 4; i++) begin
      s = 6'($urandom);
      pulse(1'b0, 8'h00, i[0], !i[0], s);
      set_wp(1'($urandom));
      n = (i == 3) ? 12 : 16;
      u_spi_host_model.frame(8'h3c, {2'b00, s, 16'($urandom)}, n, rx, miss);
      #1;
      chk("so data", rx, m_flags[s] ? 64'hffff >> (16 - n) : 64'h0);
      chk("so drive", 64'(miss), 64'h0);
      chk("so idle", so_oe_n_out, 1'b1);
    end
    u_spi_host_model.frame(8'ha5, 24'h0, 8, rx, miss);
    chk("so refused", 64'(miss), 64'h8);
    results;
  end
endmodule
